// >>> design/cirq_pending.sv
// channel interrupt summary, identity and per-channel register block, with its pending tracker
`timescale 1ns/1ps
`default_nettype none
`include "cirq_regs.svh"
// How it works
// - status bit set while channel interrupt pending
// - upper byte carries channels six to eleven
// - status held until source status read
// - status bits ignore host writes
// - part identification byte is constant
// - revision upper nibble zero, lower digit
// - ten registers for each of twelve channels
// - cleared channel gate blocks host interrupt

module cirq_top
    import cirq_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    input wire logic srst_i, // sync reset, active high
    input wire logic [`CIRQ_ADDR_W-1:0] addr_i, // register address
    input wire logic [`CIRQ_DATA_W-1:0] wdata_i, // write data
    input wire logic wr_i, // write strobe, one cycle
    input wire logic rd_i, // read strobe, one cycle
    input wire logic [`CIRQ_NUM_CH-1:0] chan_event_i, // per-channel interrupt events
    output logic [`CIRQ_DATA_W-1:0] rdata_o, // read data
    output logic rvalid_o, // read data valid
    output logic irq_o // host interrupt, active high
);

    // ****************************************
    // state and wiring
    // ****************************************
    cirq_src_if sif();
    cirq_acc_e acc;
    cirq_chvec_t pend;
    cirq_chvec_t gate_r;
    cirq_byte_t rd_mux;
    cirq_byte_t rdata_r;
    logic rvalid_r;
    logic irq_r;
    logic src_hit;
    // cells only stored here; line logic elsewhere consumes them
    cirq_byte_t cell_r [0:`CIRQ_NUM_CH_REGS-1];

    // ****************************************
    // address decode helpers
    // ****************************************

    // channel number of a per-channel address, both banks
    function automatic logic [3:0] chan_of(input logic [7:0] a);
        if (a[`CIRQ_UPPER_BANK_BIT]) begin
            chan_of = a[7:4] - 4'h2;
        end else begin
            chan_of = a[7:4];
        end
    endfunction

    // true for the ten per-channel offsets of each channel row
    function automatic logic is_chan_reg(input logic [7:0] a);
        logic hi_ok;
        logic lo_ok;
        // both banks share rows 0..5 in bits 6:4
        hi_ok = (a[6:4] <= 3'h5);
        lo_ok = ((a[3:0] >= 4'h1) && (a[3:0] <= 4'h7)) || ((a[3:0] >= 4'hA) && (a[3:0] <= 4'hC));
        is_chan_reg = hi_ok && lo_ok;
    endfunction

    // slot 0..9 inside a channel row; the gap at 8 and 9 is skipped
    function automatic logic [3:0] slot_of(input logic [7:0] a);
        if (a[3:0] <= 4'h7) begin
            slot_of = a[3:0] - 4'h1;
        end else begin
            slot_of = a[3:0] - 4'h3;
        end
    endfunction

    // flat cell index, channel major
    function automatic cirq_cell_t cell_of(input logic [7:0] a);
        cell_of = cirq_cell_t'(chan_of(a)) * cirq_cell_t'(`CIRQ_REGS_PER_CH) + cirq_cell_t'(slot_of(a));
    endfunction

    // ****************************************
    // access decode
    // ****************************************

    // read wins if the host strobes both
    always_comb begin
        if (rd_i) begin
            acc = CIRQ_RD;
        end else if (wr_i) begin
            acc = CIRQ_WR;
        end else begin
            acc = CIRQ_IDLE;
        end
    end

    assign src_hit = (acc == CIRQ_RD) && is_chan_reg(addr_i) && (addr_i[3:0] == `CIRQ_SRC_STATUS_LO);

    // ****************************************
    // pending tracker
    // ****************************************

    // source status read releases the channel
    always_comb begin
        sif.src_read = '0;
        if (src_hit) begin
            sif.src_read[chan_of(addr_i)] = 1'b1;
        end
    end

    // line events feed the sticky tracker
    assign sif.event_set = chan_event_i;
    assign pend = sif.pending;

    cirq_pending u_pend (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .src(sif)
    );

    // ****************************************
    // channel master gates
    // ****************************************

    // one gate bit per channel, both banks
    // summary offsets are not decoded for writes
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            gate_r <= {`CIRQ_GATE_RST, `CIRQ_GATE_RST};
        end else if (acc == CIRQ_WR) begin
            if (addr_i == `CIRQ_OFF_GATE_LO) begin
                gate_r[5:0] <= wdata_i[5:0];
            end
            if (addr_i == `CIRQ_OFF_GATE_HI) begin
                gate_r[11:6] <= wdata_i[5:0];
            end
        end
    end

    // ****************************************
    // per-channel cells
    // ****************************************

    // ten cells per channel, twelve channels
    always_ff @(posedge clk_sys_i) begin
        if ((acc == CIRQ_WR) && is_chan_reg(addr_i)) begin
            cell_r[cell_of(addr_i)] <= wdata_i;
        end
    end

    // ****************************************
    // read path
    // ****************************************

    always_comb begin
        case (addr_i)
            `CIRQ_OFF_GATE_LO: rd_mux = {`CIRQ_RSVD_ZERO, gate_r[5:0]};
            `CIRQ_OFF_GATE_HI: rd_mux = {`CIRQ_RSVD_ZERO, gate_r[11:6]};
            // lower bank 0..5, upper bank 6..11
            `CIRQ_OFF_SUM_LO: rd_mux = {`CIRQ_RSVD_ZERO, pend[5:0]};
            `CIRQ_OFF_SUM_HI: rd_mux = {`CIRQ_RSVD_ZERO, pend[11:6]};
            `CIRQ_OFF_PART_ID: rd_mux = `CIRQ_PART_ID;
            // upper nibble zero, revision digit below
            `CIRQ_OFF_REVISION: rd_mux = {`CIRQ_REV_UPPER, `CIRQ_REV_LOWER};
            default: begin
                if (is_chan_reg(addr_i)) begin
                    rd_mux = cell_r[cell_of(addr_i)];
                end else begin
                    rd_mux = 8'h00;
                end
            end
        endcase
    end

    // data answered one cycle after the strobe, held until the next read
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_r <= 8'h00;
        end else if (acc == CIRQ_RD) begin
            rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= (acc == CIRQ_RD);
        end
    end

    // ****************************************
    // host interrupt
    // ****************************************

    // registered so the pin never glitches
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(pend & gate_r);
        end
    end

    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;
    assign irq_o = irq_r;

    // ****************************************
    // assertions
    // ****************************************

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    a_sum_upper: assert property (
        (acc == CIRQ_RD) && (addr_i == `CIRQ_OFF_SUM_HI) |=> (rdata_r[5:0] == $past(pend[11:6])))
        else $error("upper summary byte does not match pending channels");

    a_rsvd_zero: assert property (
        (acc == CIRQ_RD) && (addr_i == `CIRQ_OFF_SUM_HI) |=> (rdata_r[7:6] == 2'h0))
        else $error("reserved summary bits not zero");

    a_part_const: assert property (
        (acc == CIRQ_RD) && (addr_i == `CIRQ_OFF_PART_ID) |=> (rdata_r == `CIRQ_PART_ID))
        else $error("identification byte changed");

    a_rev_upper: assert property (
        (acc == CIRQ_RD) && (addr_i == `CIRQ_OFF_REVISION) |=> (rdata_r[7:4] == 4'h0))
        else $error("revision upper nibble not zero");

    // upper summary write with no events leaves pending bits alone
    a_sum_rdonly: assert property (
        (acc == CIRQ_WR) && (addr_i == `CIRQ_OFF_SUM_HI) && (chan_event_i == '0) |=> (pend == $past(pend)))
        else $error("summary write changed pending bits");

    a_irq_gated: assert property (
        ((pend & gate_r) == '0) |=> !irq_r)
        else $error("interrupt raised with no gated pending channel");

    a_irq_follow: assert property (
        ((pend & gate_r) != '0) |=> irq_r)
        else $error("interrupt missing for gated pending channel");
endmodule

module cirq_pending
    import cirq_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    input wire logic srst_i, // sync reset
    cirq_src_if.tracker src // events and clears
);
    cirq_chvec_t pend_r;

    // set beats clear so an event during the read is kept
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pend_r <= '0;
        end else begin
            pend_r <= src.event_set | (pend_r & ~src.src_read);
        end
    end
    assign src.pending = pend_r;

    a_pend_set: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (src.event_set != '0) |=> ((pend_r & $past(src.event_set)) == $past(src.event_set)))
        else $error("event did not set pending bit");

    a_pend_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        1'b1 |=> (($past(pend_r) & ~$past(src.src_read) & ~pend_r) == '0))
        else $error("pending bit dropped without source read");
endmodule
`default_nettype wire

// >>> design/cirq_regs.svh
// register offsets, widths and constant values of the channel interrupt block
`ifndef CIRQ_REGS_SVH
`define CIRQ_REGS_SVH
`define CIRQ_ADDR_W 8
`define CIRQ_DATA_W 8
`define CIRQ_NUM_CH 12
`define CIRQ_HALF_CH 6
`define CIRQ_REGS_PER_CH 10
`define CIRQ_NUM_CH_REGS 120
`define CIRQ_OFF_GATE_LO 8'h60
`define CIRQ_OFF_SUM_LO 8'h61
`define CIRQ_OFF_PART_ID 8'h6E
`define CIRQ_OFF_REVISION 8'h6F
`define CIRQ_OFF_GATE_HI 8'hE0
`define CIRQ_OFF_SUM_HI 8'hE1
`define CIRQ_SRC_STATUS_LO 4'h2
`define CIRQ_UPPER_BANK_BIT 7
`define CIRQ_GATE_RST 6'h00
`define CIRQ_RSVD_ZERO 2'h0
`define CIRQ_REV_UPPER 4'h0
// identity value, arbitrary
`define CIRQ_PART_ID 8'h5A
// silicon revision digit, arbitrary
`define CIRQ_REV_LOWER 4'h3
`endif

// >>> design/cirq_pkg.sv
// types shared by the channel interrupt block
`include "cirq_regs.svh"
package cirq_pkg;
    typedef logic [`CIRQ_NUM_CH-1:0] cirq_chvec_t;
    typedef logic [6:0] cirq_cell_t;
    typedef logic [`CIRQ_DATA_W-1:0] cirq_byte_t;
    typedef enum logic [1:0] {
        CIRQ_IDLE = 2'b00,
        CIRQ_RD = 2'b01,
        CIRQ_WR = 2'b10
    } cirq_acc_e;
endpackage

// >>> design/cirq_src_if.sv
// carrier between summary logic and the per-channel pending tracker
`timescale 1ns/1ps
`default_nettype none
`include "cirq_regs.svh"
interface cirq_src_if;
    logic [`CIRQ_NUM_CH-1:0] event_set;
    logic [`CIRQ_NUM_CH-1:0] src_read;
    logic [`CIRQ_NUM_CH-1:0] pending;
    modport tracker (input event_set, input src_read, output pending);
    modport user (output event_set, output src_read, input pending);
endinterface
`default_nettype wire

// >>> verif/cirq_host.sv
// host microprocessor model on the parallel register port
`timescale 1ns/1ps
`default_nettype none
`include "cirq_regs.svh"
module cirq_host (
    input wire logic clk_sys_i, // system clock
    input wire logic [7:0] rdata_i, // read data from block
    input wire logic rvalid_i, // read data valid
    output logic [7:0] addr_o, // register address
    output logic [7:0] wdata_o, // write data
    output logic wr_o, // write strobe
    output logic rd_o // read strobe
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // idle cycle at the end keeps two writes from toggling the strobe in one step
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        wr_o = 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [7:0] d, output bit ok);
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        rd_o = 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (int k = 0; k < 4; k++) begin
            if (!ok && (rvalid_i === 1'b1)) begin
                d = rdata_i;
                ok = 1'b1;
            end
            if (!ok) begin
                @(posedge clk_sys_i);
                #1;
            end
        end
    endtask

    // service routine reads the channel source status
    task automatic read_source(input int ch, output logic [7:0] d, output bit ok);
        logic [7:0] a;
        a = {(ch < 6) ? 4'(ch) : 4'(ch + 2), `CIRQ_SRC_STATUS_LO};
        bus_read(a, d, ok);
    endtask
endmodule
`default_nettype wire

// >>> verif/cirq_tb.sv
// bench: random events and gates, summary, identity and cell reads against a model
`timescale 1ns/1ps
`default_nettype none
`include "cirq_regs.svh"
module channel_irq_status_and_id_regs_tb_top;
    logic clk_sys_i;
    logic srst_i;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic rvalid;
    logic irq;
    logic [11:0] chan_ev;
    int bad_count;
    int n_checks;
    int mdl_pend;
    int mdl_gate;
    int svc_q[$];
    int ch;
    int slot;
    logic [7:0] rd_val;
    bit rd_ok;
    logic [7:0] cell_addr;
    logic [7:0] cell_val;
    // per-channel offsets, source status slot left out
    logic [3:0] lo_tbl [0:8] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC};

    cirq_top u_dut (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .addr_i(addr),
        .wdata_i(wdata),
        .wr_i(wr),
        .rd_i(rd),
        .chan_event_i(chan_ev),
        .rdata_o(rdata),
        .rvalid_o(rvalid),
        .irq_o(irq)
    );

    cirq_host u_host (
        .clk_sys_i(clk_sys_i),
        .rdata_i(rdata),
        .rvalid_i(rvalid),
        .addr_o(addr),
        .wdata_o(wdata),
        .wr_o(wr),
        .rd_o(rd)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic read_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        u_host.bus_read(a, rd_val, rd_ok);
        if (!rd_ok) begin
            bad_count++;
            $display("ERROR %s expected valid seen timeout", what);
            give_verdict();
        end
        check(what, exp, rd_val);
    endtask

    initial begin
        srst_i = 1'b1;
        chan_ev = '0;
        bad_count = 0;
        n_checks = 0;
        mdl_pend = 0;
        mdl_gate = 0;
        void'($urandom(68));
        repeat (12) @(posedge clk_sys_i);
        #1;
        srst_i = 1'b0;
        tick(2);
        for (int it = 0; it < 24; it++) begin
            chan_ev = 12'($urandom);
            mdl_pend = mdl_pend | int'(chan_ev);
            tick(1);
            chan_ev = '0;
            mdl_gate = int'($urandom) & 'hFFF;
            u_host.bus_write(`CIRQ_OFF_GATE_LO, 8'(mdl_gate & 'h3F));
            u_host.bus_write(`CIRQ_OFF_GATE_HI, 8'((mdl_gate >> 6) & 'h3F));
            u_host.bus_write(`CIRQ_OFF_SUM_HI, 8'($urandom));
            u_host.bus_write(`CIRQ_OFF_SUM_LO, 8'($urandom));
            tick(2);
            check("irq", {7'h00, ((mdl_pend & mdl_gate) != 0)}, {7'h00, irq});
            read_check("gate upper", `CIRQ_OFF_GATE_HI, 8'((mdl_gate >> 6) & 'h3F));
            read_check("summary lower", `CIRQ_OFF_SUM_LO, 8'(mdl_pend & 'h3F));
            read_check("summary upper", `CIRQ_OFF_SUM_HI, 8'((mdl_pend >> 6) & 'h3F));
            read_check("part id", `CIRQ_OFF_PART_ID, `CIRQ_PART_ID);
            read_check("revision", `CIRQ_OFF_REVISION, {`CIRQ_REV_UPPER, `CIRQ_REV_LOWER});
            ch = int'($urandom % 12);
            slot = int'($urandom % 9);
            cell_addr = {(ch < 6) ? 4'(ch) : 4'(ch + 2), lo_tbl[slot]};
            cell_val = 8'($urandom);
            u_host.bus_write(cell_addr, cell_val);
            read_check("channel cell", cell_addr, cell_val);
            if (it[0]) begin
                for (int c = 0; c < 12; c++) begin
                    if (mdl_pend[c]) begin
                        svc_q.push_back(c);
                    end
                end
                while (svc_q.size() > 0) begin
                    ch = svc_q.pop_front();
                    u_host.read_source(ch, rd_val, rd_ok);
                    if (!rd_ok) begin
                        bad_count++;
                        $display("ERROR source status expected valid seen timeout");
                        give_verdict();
                    end
                    mdl_pend = mdl_pend & ~(1 << ch);
                end
                tick(2);
                read_check("summary after service", `CIRQ_OFF_SUM_HI, 8'((mdl_pend >> 6) & 'h3F));
                check("irq after service", 8'h00, {7'h00, irq});
            end
            $display("test %0d done", it);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
